/* sec_top.sv */
// Enhanced command and status logic of the serial peripheral controller, with its engine.
// Assumes one 40 MHz mclk, a classic Wishbone master, and serial pins resolved by the bench.
`timescale 1ns/1ps
module sec_top
  import sec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register bus
  input wire sec_wb_req_t wbReq,
  output sec_wb_rsp_t wbRsp,
  // Serial pins
  input wire sec_pin_in_t pinIn,
  output sec_pin_out_t pinOut,
  // Interrupt
  output logic irq
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic [31:0] ctrl;
  logic [5:0] rawFlags;
  logic selectEndIe;
  logic counterDisable;
  logic earlyReady;
  logic stallUntilPacket;
  logic autoDiscard;
  logic autoZeroPad;
  logic [PKT_W-1:0] packetFrames;
  logic [LIMIT_W-1:0] frameCount;
  logic txNotReady;
  logic busy;

  wire access = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
  wire regWrite = access & wbReq.we;
  wire regRead = access & ~wbReq.we;
  wire [31:0] selMask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
                         {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
  wire lowLane = wbReq.sel[0];
  wire wrCtrl = regWrite & (wbReq.adr == OFF_CTRL);
  wire wrIntClear = regWrite & lowLane & (wbReq.adr == OFF_INT_CLEAR);
  wire wrTxData = regWrite & lowLane & (wbReq.adr == OFF_TX_DATA);
  wire wrEnh = regWrite & lowLane & (wbReq.adr == OFF_ENH_CTRL);
  wire wrCmd = regWrite & lowLane & (wbReq.adr == OFF_COMMAND);
  wire wrPacket = regWrite & lowLane & (wbReq.adr == OFF_PACKET);
  wire wrLimitLow = regWrite & lowLane & (wbReq.adr == OFF_LIMIT_LOW);
  wire wrLimitHigh = regWrite & lowLane & (wbReq.adr == OFF_LIMIT_HIGH);
  wire rdRxData = regRead & (wbReq.adr == OFF_RX_DATA);

  wire enabled = ctrl[CTRL_ENABLE];
  wire master = ctrl[CTRL_MASTER];
  wire [LIMIT_W-1:0] limit = ctrl[LIMIT_LSB +: LIMIT_W];

  // ***************************************************************
  // Self-clearing command pulses
  // ***************************************************************
  wire counterClearPulse = wrCmd & wbReq.dat[CMD_COUNTER_CLEAR];
  wire txFlushPulse = wrCmd & wbReq.dat[CMD_TX_FLUSH];
  wire rxFlushPulse = wrCmd & wbReq.dat[CMD_RX_FLUSH];
  wire limitWrite = (wrCtrl & (wbReq.sel[1] | wbReq.sel[2])) | wrLimitLow | wrLimitHigh;
  wire counterClear = counterClearPulse | ~enabled | limitWrite;

  // ***************************************************************
  // Pin synchronisers and edges
  // ***************************************************************
  sec_pin_in_t pinSync;
  logic [3:0] pinSyncInv;
  logic sclkPrev;
  logic ssPrev;

  // Select travels inverted so the synchroniser resets to its idle high level
  sec_sync #(
    .W(4)
  ) u_pin_sync (
    .mclk(mclk),
    .reset(reset),
    .d(pinIn ^ 4'h4),
    .q(pinSyncInv)
  );

  assign pinSync = pinSyncInv ^ 4'h4;

  wire ssLevel = master ? pinOut.ssN : pinSync.ssN;
  wire ssRise = ssLevel & ~ssPrev;
  wire slaveActive = ~master & enabled & ~pinSync.ssN;
  wire slaveSelectFall = ~master & enabled & ~pinSync.ssN & ssPrev;
  wire slaveRise = slaveActive & pinSync.sclk & ~sclkPrev;
  wire slaveFall = slaveActive & ~pinSync.sclk & sclkPrev;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sclkPrev <= 1'b0;
      ssPrev <= 1'b1;
    end else begin
      sclkPrev <= pinSync.sclk;
      ssPrev <= ssLevel;
    end
  end

  // ***************************************************************
  // Frame queues
  // ***************************************************************
  logic [FRAME_W-1:0] txHead;
  logic txEmpty;
  logic txFull;
  logic [COUNT_W-1:0] txCount;
  logic [FRAME_W-1:0] rxHead;
  logic rxEmpty;
  logic rxFull;
  logic [COUNT_W-1:0] rxCount;
  logic [FRAME_W-1:0] shTx;
  logic [FRAME_W-1:0] shRx;
  logic [2:0] bitCount;
  logic [2:0] divCount;

  wire tick = busy & (divCount == SCLK_HALF_LAST);
  wire sampleEv = master ? (tick & ~pinOut.sclk) : slaveRise;
  wire shiftEv = master ? (tick & pinOut.sclk) : slaveFall;
  wire frameEnd = shiftEv & (bitCount == 3'h7);
  wire [FRAME_W-1:0] rxFrame = shRx;
  wire rxAccepted = frameEnd & ~autoDiscard;
  wire rxPush = rxAccepted & ~rxFull;
  wire rxOverrun = rxAccepted & rxFull;

  wire limitActive = ~counterDisable & (limit != '0);
  wire limitHeld = limitActive & (frameCount >= limit);
  wire countReach = frameEnd & limitActive & ((frameCount + 1'b1) == limit);
  wire txAvail = ~txEmpty | autoZeroPad;
  wire packetReady = ~stallUntilPacket | (txCount >= COUNT_W'(packetFrames));
  wire startNow = master & enabled & ~busy & txAvail & ~limitHeld & packetReady;
  wire slaveReload = frameEnd & slaveActive;
  wire loadEv = startNow | slaveSelectFall | slaveReload;
  wire [FRAME_W-1:0] loadData = txEmpty ? '0 : txHead;
  wire txPop = loadEv & ~txEmpty;
  wire txUnderrun = ~master & (slaveSelectFall | slaveReload) & txEmpty & ~autoZeroPad;
  wire txShiftedEv = countReach | (frameEnd & ~limitActive & txEmpty);

  sec_fifo #(
    .W(FRAME_W),
    .DEPTH(FIFO_DEPTH),
    .CW(COUNT_W)
  ) u_tx_fifo (
    .mclk(mclk),
    .reset(reset),
    .flush(txFlushPulse),
    .push(wrTxData & ~txFull),
    .pushData(wbReq.dat[FRAME_W-1:0]),
    .pop(txPop),
    .head(txHead),
    .empty(txEmpty),
    .full(txFull),
    .count(txCount)
  );

  sec_fifo #(
    .W(FRAME_W),
    .DEPTH(FIFO_DEPTH),
    .CW(COUNT_W)
  ) u_rx_fifo (
    .mclk(mclk),
    .reset(reset),
    .flush(rxFlushPulse),
    .push(rxPush),
    .pushData(rxFrame),
    .pop(rdRxData & ~rxEmpty),
    .head(rxHead),
    .empty(rxEmpty),
    .full(rxFull),
    .count(rxCount)
  );

  // ***************************************************************
  // Shift engine
  // ***************************************************************
  wire inBit = master ? pinSync.miso : pinSync.mosi;
  wire next_txBit = loadEv ? loadData[FRAME_W-1] :
                    (shiftEv ? shTx[FRAME_W-2] : pinOut.mosi);
  wire next_sclk = busy & master & enabled & (tick ? ~pinOut.sclk : pinOut.sclk);
  wire next_ssN = ~(master & enabled & (busy | startNow));

  always_ff @(posedge mclk) begin
    if (reset || !enabled) begin
      busy <= 1'b0;
    end else if (startNow) begin
      busy <= 1'b1;
    end else if (master && frameEnd) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !busy || tick) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shTx <= '0;
      bitCount <= '0;
    end else if (loadEv) begin
      shTx <= loadData;
      bitCount <= '0;
    end else if (shiftEv) begin
      shTx <= {shTx[FRAME_W-2:0], 1'b0};
      bitCount <= bitCount + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shRx <= '0;
    end else if (sampleEv) begin
      shRx <= {shRx[FRAME_W-2:0], inBit};
    end
  end

  // ***************************************************************
  // Frame counter
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (reset || counterClear) begin
      frameCount <= '0;
    end else if (frameEnd && !counterDisable) begin
      frameCount <= frameCount + 1'b1;
    end
  end

  // ***************************************************************
  // Control, enhanced control, packet size
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl <= (ctrl & ~selMask) | (wbReq.dat & selMask);
    end else if (wrLimitLow) begin
      ctrl[LIMIT_LSB +: 8] <= wbReq.dat[7:0];
    end else if (wrLimitHigh) begin
      ctrl[LIMIT_LSB + 8 +: 8] <= wbReq.dat[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      selectEndIe <= 1'b0;
      counterDisable <= 1'b0;
      packetFrames <= '0;
    end else begin
      if (wrEnh) begin
        selectEndIe <= wbReq.dat[ENH_SELECT_END_IE];
        counterDisable <= wbReq.dat[ENH_COUNTER_DISABLE];
      end
      if (wrPacket) begin
        packetFrames <= wbReq.dat[PKT_W-1:0];
      end
    end
  end

  // ***************************************************************
  // Sticky command bits
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      earlyReady <= 1'b0;
      stallUntilPacket <= 1'b0;
      autoDiscard <= 1'b0;
      autoZeroPad <= 1'b0;
    end else if (wrCmd) begin
      earlyReady <= wbReq.dat[CMD_EARLY_READY];
      stallUntilPacket <= wbReq.dat[CMD_STALL];
      autoDiscard <= wbReq.dat[CMD_AUTO_DISCARD];
      autoZeroPad <= wbReq.dat[CMD_AUTO_PAD];
    end else begin
      if (frameEnd) begin
        earlyReady <= 1'b0;
      end
      if (startNow) begin
        stallUntilPacket <= 1'b0;
      end
      if (countReach || (!master && ssRise)) begin
        autoDiscard <= 1'b0;
      end
      if (countReach) begin
        autoZeroPad <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Raw and masked flags
  // ***************************************************************
  wire [5:0] flagSet = {ssRise, 1'b0, txUnderrun, rxOverrun, rxPush, txShiftedEv};
  wire [5:0] flagClear = wrIntClear ? wbReq.dat[5:0] : 6'h00;
  wire [5:0] next_rawFlags = (rawFlags & ~flagClear) | flagSet;
  wire [5:0] flagEnable = {selectEndIe, 1'b0, ctrl[CTRL_IE_TX_UNDERRUN],
                           ctrl[CTRL_IE_RX_OVERFLOW], ctrl[CTRL_IE_RX_READY],
                           ctrl[CTRL_IE_TX_SHIFTED]};
  wire [5:0] maskedFlags = rawFlags & flagEnable;
  wire [5:0] next_masked = next_rawFlags & flagEnable;
  wire next_txNotReady = ~master & enabled & ~earlyReady &
                         (txCount < COUNT_W'(packetFrames));

  always_ff @(posedge mclk) begin
    if (reset) begin
      rawFlags <= FLAGS_RESET;
      irq <= 1'b0;
      txNotReady <= 1'b0;
    end else begin
      rawFlags <= next_rawFlags;
      irq <= |next_masked;
      txNotReady <= next_txNotReady;
    end
  end

  // ***************************************************************
  // Read mux and bus answer
  // ***************************************************************
  wire [31:0] statusWord = {24'h000000, 1'b0, rxEmpty, txEmpty, txFull,
                            rxFull, pinSync.ssN, busy, txNotReady};
  wire [31:0] enhWord = {26'h0, selectEndIe, 2'b00, counterDisable, 2'b00};
  wire [31:0] cmdWord = {25'h0, earlyReady, stallUntilPacket, 3'b000,
                         autoDiscard, autoZeroPad};
  wire [31:0] rdData =
      (wbReq.adr == OFF_CTRL) ? ctrl :
      (wbReq.adr == OFF_RX_DATA) ? {24'h000000, rxHead} :
      (wbReq.adr == OFF_STATUS) ? statusWord :
      (wbReq.adr == OFF_RAW_FLAGS) ? {26'h0, rawFlags} :
      (wbReq.adr == OFF_MASKED_FLAGS) ? {26'h0, maskedFlags} :
      (wbReq.adr == OFF_ENH_CTRL) ? enhWord :
      (wbReq.adr == OFF_COMMAND) ? cmdWord :
      (wbReq.adr == OFF_PACKET) ? {26'h0, packetFrames} :
      (wbReq.adr == OFF_FRAME_COUNT) ? {16'h0000, frameCount} :
      (wbReq.adr == OFF_LIMIT_LOW) ? {24'h000000, limit[7:0]} :
      (wbReq.adr == OFF_LIMIT_HIGH) ? {24'h000000, limit[15:8]} :
      32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (reset) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= access;
      wbRsp.dat <= regRead ? rdData : 32'h0000_0000;
    end
  end

  // ***************************************************************
  // Pin drivers
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinOut <= '0;
      pinOut.ssN <= 1'b1;
    end else begin
      pinOut.sclk <= next_sclk;
      pinOut.sclkOe <= master & enabled;
      pinOut.ssN <= next_ssN;
      pinOut.ssOe <= master & enabled;
      pinOut.mosi <= next_txBit;
      pinOut.mosiOe <= master & enabled;
      pinOut.miso <= next_txBit;
      pinOut.misoOe <= slaveActive;
    end
  end

endmodule

/* sec_pkg.sv */
// Package for the enhanced command and status logic of the serial peripheral controller.
// Assumes a single 40 MHz clock, a classic Wishbone slave port and 8-bit serial frames.
package sec_pkg;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } sec_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sec_wb_rsp_t;

  typedef struct packed {
    logic sclk;
    logic ssN;
    logic mosi;
    logic miso;
  } sec_pin_in_t;

  typedef struct packed {
    logic sclk;
    logic sclkOe;
    logic ssN;
    logic ssOe;
    logic mosi;
    logic mosiOe;
    logic miso;
    logic misoOe;
  } sec_pin_out_t;

  // ***************************************************************
  // Register offsets (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h04;
  localparam logic [7:0] OFF_RX_DATA = 8'h08;
  localparam logic [7:0] OFF_TX_DATA = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RAW_FLAGS = 8'h14;
  localparam logic [7:0] OFF_MASKED_FLAGS = 8'h18;
  localparam logic [7:0] OFF_ENH_CTRL = 8'h1c;
  localparam logic [7:0] OFF_COMMAND = 8'h20;
  localparam logic [7:0] OFF_PACKET = 8'h24;
  localparam logic [7:0] OFF_FRAME_COUNT = 8'h28;
  localparam logic [7:0] OFF_LIMIT_LOW = 8'h44;
  localparam logic [7:0] OFF_LIMIT_HIGH = 8'h48;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_IE_TX_SHIFTED = 5;
  localparam int CTRL_IE_RX_READY = 4;
  localparam int CTRL_IE_RX_OVERFLOW = 6;
  localparam int CTRL_IE_TX_UNDERRUN = 7;
  localparam int LIMIT_LSB = 8;
  localparam int LIMIT_W = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam int FLAG_SELECT_END = 5;
  localparam int FLAG_TX_UNDERRUN = 3;
  localparam int FLAG_RX_OVERFLOW = 2;
  localparam int FLAG_RX_READY = 1;
  localparam int FLAG_TX_SHIFTED = 0;
  localparam int FLAG_W = 6;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  localparam int ENH_SELECT_END_IE = 5;
  localparam int ENH_COUNTER_DISABLE = 2;

  localparam int CMD_EARLY_READY = 6;
  localparam int CMD_STALL = 5;
  localparam int CMD_COUNTER_CLEAR = 4;
  localparam int CMD_TX_FLUSH = 3;
  localparam int CMD_RX_FLUSH = 2;
  localparam int CMD_AUTO_DISCARD = 1;
  localparam int CMD_AUTO_PAD = 0;

  // ***************************************************************
  // Sizes and timing
  // ***************************************************************
  localparam int FRAME_W = 8;
  localparam int FIFO_DEPTH = 64;
  localparam int COUNT_W = 7;
  localparam int PKT_W = 6;
  localparam int SCLK_HALF = 4;
  localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF - 1);

endpackage

/* sec_sync.sv */
// Two-stage synchroniser for levels arriving from outside the mclk domain.
// Assumes each bit is an independent level; the first stage feeds only the second.
`timescale 1ns/1ps
module sec_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1;

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

/* sec_fifo.sv */
// Synchronous FIFO with flush, used for the transmit and receive frame queues.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
module sec_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64,
  parameter int CW = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic flush,
  input wire logic push,
  input wire logic [W-1:0] pushData,
  input wire logic pop,
  // State
  output logic [W-1:0] head,
  output logic empty,
  output logic full,
  output logic [CW-1:0] count
);

  logic [W-1:0] mem [DEPTH];
  logic [CW-2:0] wrPtr;
  logic [CW-2:0] rdPtr;

  assign head = mem[rdPtr];
  assign empty = (count == '0);
  assign full = (count == CW'(DEPTH));

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= pushData;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

endmodule

/* sec_top_assertions.sv */
// Checker for sec_top: bus answer timing, serial framing and command readback.
// Assumes it is bound to sec_top and that masters hold requests until ack.
`timescale 1ns/1ps
module sec_top_assertions
  import sec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Watched ports
  input wire sec_wb_req_t wbReq,
  input wire sec_wb_rsp_t wbRsp,
  input wire sec_pin_out_t pinOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence taken_s;
    wbReq.cyc && wbReq.stb && !wbRsp.ack;
  endsequence
  sequence read_of_s(logic [7:0] a);
    wbRsp.ack && !$past(wbReq.we) && $past(wbReq.adr) == a;
  endsequence
  sequence sclk_high_s;
    pinOut.sclk[*4] ##1 !pinOut.sclk;
  endsequence
  ack_answer_a: assert property (taken_s |=> wbRsp.ack)
    else $error("ack missing");
  ack_single_a: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack longer than one cycle");
  read_idle_a: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
    else $error("read data outside ack");
  frame_start_a: assert property ($fell(pinOut.ssN) |-> ##4 $rose(pinOut.sclk))
    else $error("first sclk rise late");
  sclk_half_a: assert property ($rose(pinOut.sclk) |-> sclk_high_s)
    else $error("sclk high time wrong");
  sclk_idle_a: assert property (pinOut.ssN |-> !pinOut.sclk)
    else $error("sclk high while deselected");
  cmd_pulse_a: assert property (
    read_of_s(OFF_COMMAND) |-> wbRsp.dat[31:7] == 25'h0 && wbRsp.dat[4:2] == 3'h0)
    else $error("command pulse bits read set");
  enh_fields_a: assert property (
    read_of_s(OFF_ENH_CTRL) |-> (wbRsp.dat & ~32'h24) == 32'h0)
    else $error("enhanced control stray bits");
  raw_fields_a: assert property (
    read_of_s(OFF_RAW_FLAGS) |-> wbRsp.dat[31:6] == 26'h0 && !wbRsp.dat[4])
    else $error("raw flags stray bits");
endmodule

bind sec_top sec_top_assertions i_chk (.mclk(mclk), .reset(reset), .wbReq(wbReq),
  .wbRsp(wbRsp), .pinOut(pinOut));

/* sec_remote_slave.sv */
// Remote serial slave answering a mode 0 master with a counting reply byte.
// Assumes 8-bit frames, MSB first, select low only within transfers.
`timescale 1ns/1ps
module sec_remote_slave (
  // Serial pins
  input wire logic sclk,
  input wire logic ssN,
  input wire logic mosi,
  output logic miso,
  // Observation
  output logic [7:0] got,
  output int frames
);
  logic [7:0] shiftIn = 8'h00;
  logic [7:0] reply = 8'ha5;
  int bitN = 0;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    frames = 0;
  end
  always @(negedge ssN) begin
    bitN = 0;
    miso = reply[7];
  end
  always @(posedge sclk) if (!ssN) begin
    shiftIn = {shiftIn[6:0], mosi};
    bitN++;
    if (bitN == 8) begin
      got = shiftIn;
      frames++;
      reply++;
      bitN = 0;
    end
  end
  always @(negedge sclk) if (!ssN) miso = reply[3'(7 - bitN)];
  // Released line must not keep showing the last bit
  always @(posedge ssN) miso = ~miso;
endmodule

/* spi_enhanced_command_status_test.sv */
// Self-checking bench for sec_top in master mode against a remote serial slave,
// and in slave mode with the bench driving the serial lines as master.
// Assumes Wishbone tasks as bus master and one 40 MHz clock.
`timescale 1ns/1ps
module spi_enhanced_command_status_test;
  import sec_pkg::*;
  logic mclk, reset, irq, slvMiso;
  logic extSclk, extSsN, extMosi;
  sec_wb_req_t wbReq;
  sec_wb_rsp_t wbRsp;
  sec_pin_in_t pinIn;
  sec_pin_out_t pinOut;
  logic [7:0] got;
  logic [31:0] q;
  int frames, errorCnt, totalChecks;
  // Lines the design leaves undriven come from the bench; select idles high
  assign pinIn = '{pinOut.sclkOe ? pinOut.sclk : extSclk, pinOut.ssOe ? pinOut.ssN : extSsN,
    pinOut.mosiOe ? pinOut.mosi : extMosi, pinOut.misoOe ? pinOut.miso : slvMiso};
  sec_top i_dut (.mclk(mclk), .reset(reset), .wbReq(wbReq), .wbRsp(wbRsp),
    .pinIn(pinIn), .pinOut(pinOut), .irq(irq));
  sec_remote_slave i_slave (.sclk(pinIn.sclk), .ssN(pinIn.ssN), .mosi(pinIn.mosi),
    .miso(slvMiso), .got(got), .frames(frames));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic wrapUp;
    if (errorCnt == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wbReq <= '{1'b1, 1'b1, we, 4'hf, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 40);
    q = wbRsp.dat;
    wbReq <= '0;
    if (n >= 40) begin
      errorCnt++;
      wrapUp();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic waitFrames(input int n);
    int k;
    for (k = 0; k < 3000 && frames < n; k++) @(posedge mclk);
    if (frames < n) begin
      errorCnt++;
      wrapUp();
    end
  endtask
  task automatic resetValues;
    rd(OFF_RAW_FLAGS, 32'h0);
    rd(OFF_ENH_CTRL, 32'h0);
    rd(OFF_COMMAND, 32'h0);
    rd(8'h30, 32'h0);
  endtask
  task automatic regAccess;
    wr(OFF_ENH_CTRL, 32'h24);
    rd(OFF_ENH_CTRL, 32'h24);
    wr(OFF_ENH_CTRL, 32'h0);
    wr(OFF_COMMAND, 32'h7f);
    rd(OFF_COMMAND, 32'h63);
    wr(OFF_COMMAND, 32'h0);
  endtask
  task automatic frameLimit;
    wr(OFF_CTRL, 32'h103);
    wr(OFF_TX_DATA, 32'h3c);
    waitFrames(1);
    chk(got, 8'h3c);
    repeat (20) @(posedge mclk);
    rd(OFF_RAW_FLAGS, 32'h23);
    rd(OFF_RX_DATA, 32'ha5);
    wr(OFF_TX_DATA, 32'hc3);
    repeat (80) @(posedge mclk);
    chk(frames, 1);
    wr(OFF_COMMAND, 32'h10);
    waitFrames(2);
    chk(got, 8'hc3);
  endtask
  task automatic flushes;
    wr(OFF_TX_DATA, 32'h77);
    wr(OFF_COMMAND, 32'h1c);
    repeat (80) @(posedge mclk);
    chk(frames, 2);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(q & 32'h60, 32'h60);
  endtask
  task automatic irqPath;
    wr(OFF_CTRL, 32'h123);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    rd(OFF_MASKED_FLAGS, 32'h01);
    wr(OFF_INT_CLEAR, 32'h3f);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    rd(OFF_RAW_FLAGS, 32'h0);
  endtask
  task automatic stallPad;
    wr(OFF_CTRL, 32'h3);
    wr(OFF_ENH_CTRL, 32'h20);
    wr(OFF_PACKET, 32'h2);
    wr(OFF_COMMAND, 32'h20);
    wr(OFF_TX_DATA, 32'h11);
    repeat (80) @(posedge mclk);
    chk(frames, 2);
    wr(OFF_TX_DATA, 32'h22);
    waitFrames(4);
    chk(got, 8'h22);
    rd(OFF_COMMAND, 32'h0);
    repeat (20) @(posedge mclk);
    chk(irq, 1'b1);
    wr(OFF_CTRL, 32'h303);
    wr(OFF_TX_DATA, 32'h5a);
    wr(OFF_COMMAND, 32'h7);
    waitFrames(7);
    chk(got, 8'h00);
    repeat (20) @(posedge mclk);
    rd(OFF_COMMAND, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(q & 32'h40, 32'h40);
  endtask
  task automatic rxOverflow;
    wr(OFF_LIMIT_LOW, 32'h0);
    rd(OFF_FRAME_COUNT, 32'h0);
    wr(OFF_COMMAND, 32'h1);
    waitFrames(45);
    waitFrames(80);
    wr(OFF_COMMAND, 32'h0);
    repeat (80) @(posedge mclk);
    bus(1'b0, OFF_RAW_FLAGS, 32'h0);
    chk(q & 32'h04, 32'h04);
  endtask
  task automatic slaveLink;
    int i;
    logic [7:0] b;
    b = 8'h96;
    wr(OFF_CTRL, 32'h1);
    wr(OFF_INT_CLEAR, 32'h3f);
    wr(OFF_COMMAND, 32'h04);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    wr(OFF_COMMAND, 32'h40);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(q & 32'h1, 32'h0);
    rd(OFF_COMMAND, 32'h40);
    extSsN <= 1'b0;
    for (i = 7; i >= 0; i--) begin
      extMosi <= b[i];
      repeat (4) @(posedge mclk);
      extSclk <= 1'b1;
      repeat (4) @(posedge mclk);
      extSclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    rd(OFF_COMMAND, 32'h0);
    extSsN <= 1'b1;
    repeat (8) @(posedge mclk);
    bus(1'b0, OFF_RAW_FLAGS, 32'h0);
    chk(q & 32'h2a, 32'h2a);
    rd(OFF_RX_DATA, 32'h96);
  endtask
  initial begin
    errorCnt = 0;
    totalChecks = 0;
    reset = 1'b1;
    wbReq = '0;
    extSclk = 1'b0;
    extSsN = 1'b1;
    extMosi = 1'b0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    resetValues();
    regAccess();
    frameLimit();
    flushes();
    irqPath();
    stallPad();
    rxOverflow();
    slaveLink();
    wrapUp();
  end
endmodule
